// [hw/spio_pkg.sv]
package spio_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_PIO_ENABLE    = 8'h00;
  localparam logic [7:0] OFS_PIO_DISABLE   = 8'h04;
  localparam logic [7:0] OFS_PIN_FUNC_STAT = 8'h08;
  localparam logic [7:0] OFS_OE_SET        = 8'h10;
  localparam logic [7:0] OFS_OE_CLEAR      = 8'h14;
  localparam logic [7:0] OFS_OE_STAT       = 8'h18;
  localparam logic [7:0] OFS_LVL_SET       = 8'h30;
  localparam logic [7:0] OFS_LVL_CLEAR     = 8'h34;
  localparam logic [7:0] OFS_LVL_STAT      = 8'h38;
  localparam logic [7:0] OFS_PIN_STAT      = 8'h3c;
  localparam logic [7:0] OFS_OD_SET        = 8'h40;
  localparam logic [7:0] OFS_OD_CLEAR      = 8'h44;
  localparam logic [7:0] OFS_OD_STAT       = 8'h48;
  localparam logic [7:0] OFS_CLK_SET       = 8'h50;
  localparam logic [7:0] OFS_CLK_CLEAR     = 8'h54;
  localparam logic [7:0] OFS_CLK_STAT      = 8'h58;
  localparam logic [7:0] OFS_UNIT_CTRL     = 8'h60;
  localparam logic [7:0] OFS_UNIT_STAT     = 8'h70;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int PIN_LSB       = 16;
  localparam int PIN_COUNT     = 7;
  localparam int CLK_PIO_BIT   = 0;
  localparam int CLK_SER_BIT   = 1;
  localparam int CTRL_RST_BIT  = 0;
  localparam int CTRL_EN_BIT   = 1;
  localparam int CTRL_DIS_BIT  = 2;
  localparam int STAT_TXE_BIT  = 1;
  localparam int STAT_FLT_BIT  = 2;
  localparam int STAT_ENA_BIT  = 8;
  localparam int STAT_DRN_BIT  = 9;

  // ----------------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------------
  localparam logic [6:0] RST_PIO_SEL = 7'h7f;
  localparam logic [6:0] RST_OE      = 7'h00;
  localparam logic [6:0] RST_ODATA   = 7'h00;
  localparam logic [6:0] RST_ODRAIN  = 7'h00;
  localparam logic [1:0] RST_CLK     = 2'h0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    UNIT_OFF,
    UNIT_ON,
    UNIT_DRAIN
  } spio_unit_type;

  typedef struct packed {
    logic [6:0] pio_sel;
    logic [6:0] oe;
    logic [6:0] odata;
    logic [6:0] odrain;
  } spio_cfg_type;

  typedef struct packed {
    logic [6:0] out;
    logic [6:0] oe;
  } spio_drive_type;

  typedef struct packed {
    spio_cfg_type  cfg;
    logic [1:0]    clk_gate;
    spio_unit_type unit;
    logic          tx_empty;
    logic          fault_seen;
    logic [6:0]    sync1;
    logic [6:0]    sync2;
    logic [6:0]    sync3;
    logic [6:0]    level;
    logic [31:0]   prdata;
    logic          slverr;
  } spio_state_type;

  localparam spio_cfg_type RST_CFG = '{
    pio_sel: RST_PIO_SEL,
    oe:      RST_OE,
    odata:   RST_ODATA,
    odrain:  RST_ODRAIN
  };

  // Seven pin bits sit at 22..16 of every pin register
  function automatic logic [6:0] pin_field(input logic [31:0] w);
    pin_field = w[PIN_LSB +: PIN_COUNT];
  endfunction : pin_field

  function automatic logic [31:0] pin_word(input logic [6:0] v);
    pin_word = {9'h000, v, 16'h0000};
  endfunction : pin_word

endpackage : spio_pkg

// [hw/spio_pin_ctrl.sv]
// Summary of operation
// - Function status bits 16..22 read one for general I/O, zero for serial function.
// - Output-enable status reads one per output pin, zero per input pin.
// - Output enable/disable writes switch addressed pins to output or input.
// - Set/clear output writes program addressed pin levels to one or zero.
// - Output level status reads back programmed output levels.
// - Pin level status returns sampled pin levels, not programmed data.
// - Open-drain set/clear writes select open-drain or push-pull per pin.
// - Open-drain status reads one where open-drain driving is set.
// - Clock set/clear writes turn pin clock (bit 0), serial clock (bit 1).
// - Clock status shows pin clock in bit 0, serial clock in bit 1.
// - Clock status survives soft reset; only hardware reset clears it.
// - Control bit 0 soft-resets all registers but clock status and pin level status; zeros do nothing.
// - Control bit 1 enables the unit for transmit and receive.
// - Control bit 2 disables the unit, serial-function pins become inputs, transfers stop.
// - Disable during a transfer waits for that transfer to finish.
// - Enable and disable written together act as disable.
// - After a mode fault the unit stays disabled until enabled again.
// - Transmit-empty flag is zero when disabled or reset; enable sets it.
`timescale 1ns/10ps
module spio_pin_ctrl #(
  parameter int ADDR_W = 8
) (
  // Clock, reset, clock enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins: serial_clock_pin, miso, mosi, chip_select_pin_n[3:0]
  input  wire logic [6:0]  pin_in,
  output logic      [6:0]  pin_out,
  output logic      [6:0]  pin_oe,
  // Serial engine side
  input  wire logic [6:0]  ser_out,
  input  wire logic [6:0]  ser_oe,
  input  wire logic        xfer_busy,
  input  wire logic        master_conflict_fault,
  input  wire logic        tx_load,
  input  wire logic        tx_take,
  output logic      [6:0]  ser_pin_level,
  output logic             unit_enabled,
  output logic             transmit_holding_empty_flag,
  output logic             soft_reset_pulse,
  output logic             pio_clk_on,
  output logic             ser_clk_on
);

  // ----------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------
  // The decode slices paddr[7:0], so fewer than eight bits cannot work
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_addr_check
    $error("spio_pin_ctrl: ADDR_W must lie between 8 and 32");
  end

  // Pin registers and the pin ports are all seven bits wide
  if (spio_pkg::PIN_COUNT != 7) begin : g_pin_check
    $error("spio_pin_ctrl: PIN_COUNT must be 7");
  end

  spio_pkg::spio_state_type q;
  spio_pkg::spio_state_type d;

  logic        setup_phase;
  logic        wr_take;
  logic [7:0]  addr8;
  logic [6:0]  wbits;
  logic        soft_rst;
  logic        cmd_en;
  logic        cmd_dis;
  logic        active;
  logic        bus_hit;
  spio_pkg::spio_drive_type drv;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  // Address fits 8 bits; upper bits above the map must be zero to hit
  always_comb begin
    addr8 = paddr[7:0];
  end

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    logic hi_zero;
    hi_zero = 1'b1;
    for (int i = 8; i < ADDR_W; i++) begin
      if (a[i]) begin
        hi_zero = 1'b0;
      end
    end
    addr_hit = hi_zero;
  endfunction : addr_hit

  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      spio_pkg::OFS_PIO_ENABLE,  spio_pkg::OFS_PIO_DISABLE, spio_pkg::OFS_PIN_FUNC_STAT,
      spio_pkg::OFS_OE_SET,      spio_pkg::OFS_OE_CLEAR,    spio_pkg::OFS_OE_STAT,
      spio_pkg::OFS_LVL_SET,     spio_pkg::OFS_LVL_CLEAR,   spio_pkg::OFS_LVL_STAT,
      spio_pkg::OFS_PIN_STAT,    spio_pkg::OFS_OD_SET,      spio_pkg::OFS_OD_CLEAR,
      spio_pkg::OFS_OD_STAT,     spio_pkg::OFS_CLK_SET,     spio_pkg::OFS_CLK_CLEAR,
      spio_pkg::OFS_CLK_STAT,    spio_pkg::OFS_UNIT_CTRL,   spio_pkg::OFS_UNIT_STAT: begin
        is_mapped = 1'b1;
      end
      default: begin
        is_mapped = 1'b0;
      end
    endcase
  endfunction : is_mapped

  // Read data is captured in the setup cycle so prdata comes from a flop
  // and the access phase can finish in a single cycle.
  assign setup_phase = psel & ~penable & clk_en;
  assign pready      = psel & penable & clk_en;
  assign wr_take     = pready & pwrite;
  assign wbits       = spio_pkg::pin_field(pwdata);
  assign bus_hit     = is_mapped(addr8) & addr_hit(paddr);

  // Only a write to the control offset fires a command
  assign soft_rst = wr_take & (addr8 == spio_pkg::OFS_UNIT_CTRL) & addr_hit(paddr)
                    & pwdata[spio_pkg::CTRL_RST_BIT];
  assign cmd_en   = wr_take & (addr8 == spio_pkg::OFS_UNIT_CTRL) & addr_hit(paddr)
                    & pwdata[spio_pkg::CTRL_EN_BIT];
  assign cmd_dis  = wr_take & (addr8 == spio_pkg::OFS_UNIT_CTRL) & addr_hit(paddr)
                    & pwdata[spio_pkg::CTRL_DIS_BIT];

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  function automatic logic [31:0] read_word(input spio_pkg::spio_state_type s,
                                            input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      spio_pkg::OFS_PIN_FUNC_STAT: begin
        w = spio_pkg::pin_word(s.cfg.pio_sel);
      end
      spio_pkg::OFS_OE_STAT: begin
        w = spio_pkg::pin_word(s.cfg.oe);
      end
      spio_pkg::OFS_LVL_STAT: begin
        w = spio_pkg::pin_word(s.cfg.odata);
      end
      spio_pkg::OFS_PIN_STAT: begin
        w = spio_pkg::pin_word(s.level);
      end
      spio_pkg::OFS_OD_STAT: begin
        w = spio_pkg::pin_word(s.cfg.odrain);
      end
      spio_pkg::OFS_CLK_STAT: begin
        w[1:0] = s.clk_gate;
      end
      spio_pkg::OFS_UNIT_STAT: begin
        // A draining unit still counts as enabled
        w[spio_pkg::STAT_TXE_BIT] = s.tx_empty;
        w[spio_pkg::STAT_FLT_BIT] = s.fault_seen;
        w[spio_pkg::STAT_ENA_BIT] = (s.unit != spio_pkg::UNIT_OFF);
        w[spio_pkg::STAT_DRN_BIT] = (s.unit == spio_pkg::UNIT_DRAIN);
      end
      default: begin
        // Write-only and reserved offsets read as zero
        w = 32'h0000_0000;
      end
    endcase
    read_word = w;
  endfunction : read_word

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    d = q;

    // A low clock enable freezes every bit of state
    if (clk_en) begin
      // Pin sampling runs only while the pin-controller clock is on
      if (q.clk_gate[spio_pkg::CLK_PIO_BIT]) begin
        // Stages two and three must agree, so a one-cycle glitch is dropped
        d.sync1 = pin_in;
        d.sync2 = q.sync1;
        d.sync3 = q.sync2;
        for (int i = 0; i < spio_pkg::PIN_COUNT; i++) begin
          if (q.sync2[i] == q.sync3[i]) begin
            d.level[i] = q.sync3[i];
          end
        end
      end

      // Bus answer captured in setup
      if (setup_phase) begin
        d.slverr = ~bus_hit;
        d.prdata = (pwrite | ~bus_hit) ? 32'h0000_0000 : read_word(q, addr8);
      end

      // Register writes; read-only offsets ignore writes
      // Set/clear pairs spare software a read-modify-write
      if (wr_take & addr_hit(paddr)) begin
        case (addr8)
          spio_pkg::OFS_PIO_ENABLE: begin
            d.cfg.pio_sel = q.cfg.pio_sel | wbits;
          end
          spio_pkg::OFS_PIO_DISABLE: begin
            d.cfg.pio_sel = q.cfg.pio_sel & ~wbits;
          end
          spio_pkg::OFS_OE_SET: begin
            d.cfg.oe = q.cfg.oe | wbits;
          end
          spio_pkg::OFS_OE_CLEAR: begin
            d.cfg.oe = q.cfg.oe & ~wbits;
          end
          spio_pkg::OFS_LVL_SET: begin
            d.cfg.odata = q.cfg.odata | wbits;
          end
          spio_pkg::OFS_LVL_CLEAR: begin
            d.cfg.odata = q.cfg.odata & ~wbits;
          end
          spio_pkg::OFS_OD_SET: begin
            d.cfg.odrain = q.cfg.odrain | wbits;
          end
          spio_pkg::OFS_OD_CLEAR: begin
            d.cfg.odrain = q.cfg.odrain & ~wbits;
          end
          spio_pkg::OFS_CLK_SET: begin
            d.clk_gate = q.clk_gate | pwdata[1:0];
          end
          spio_pkg::OFS_CLK_CLEAR: begin
            d.clk_gate = q.clk_gate & ~pwdata[1:0];
          end
          default: begin
            d.cfg = d.cfg;
          end
        endcase
      end

      // Transmit-holding flag follows the engine while the unit runs
      // Take is applied last, so a load and take together leave it set
      if (q.unit != spio_pkg::UNIT_OFF) begin
        if (tx_load) begin
          d.tx_empty = 1'b0;
        end
        if (tx_take) begin
          d.tx_empty = 1'b1;
        end
      end

      // Unit state
      case (q.unit)
        spio_pkg::UNIT_OFF: begin
          // Serial pins stay released until the next enable
          d.tx_empty = 1'b0;
        end
        spio_pkg::UNIT_ON: begin
          if (master_conflict_fault) begin
            d.unit       = spio_pkg::UNIT_OFF;
            d.fault_seen = 1'b1;
            d.tx_empty   = 1'b0;
          end
        end
        spio_pkg::UNIT_DRAIN: begin
          // The unit goes quiet once the transfer in flight ends or a mode fault hits
          if (!xfer_busy || master_conflict_fault) begin
            d.unit     = spio_pkg::UNIT_OFF;
            d.tx_empty = 1'b0;
          end
          if (master_conflict_fault) begin
            d.fault_seen = 1'b1;
          end
        end
        default: begin
          d.unit = spio_pkg::UNIT_OFF;
        end
      endcase

      // Soft reset: everything but clock status and the live pin sampler
      if (soft_rst) begin
        d.cfg        = spio_pkg::RST_CFG;
        d.unit       = spio_pkg::UNIT_OFF;
        d.tx_empty   = 1'b0;
        d.fault_seen = 1'b0;
        // Clock status sits outside the soft-reset scope on purpose
        d.clk_gate   = q.clk_gate;
      end

      // Disable beats enable in the same write
      if (cmd_dis) begin
        // Draining only makes sense for a running unit not being reset
        if (xfer_busy && (q.unit != spio_pkg::UNIT_OFF) && !soft_rst) begin
          d.unit = spio_pkg::UNIT_DRAIN;
        end else begin
          d.unit     = spio_pkg::UNIT_OFF;
          d.tx_empty = 1'b0;
        end
      end else if (cmd_en) begin
        d.unit       = spio_pkg::UNIT_ON;
        d.tx_empty   = 1'b1;
        d.fault_seen = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Only a hardware reset clears the clock status bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.cfg        <= spio_pkg::RST_CFG;
      q.clk_gate   <= spio_pkg::RST_CLK;
      q.unit       <= spio_pkg::UNIT_OFF;
      q.tx_empty   <= 1'b0;
      q.fault_seen <= 1'b0;
      q.sync1      <= 7'h00;
      q.sync2      <= 7'h00;
      q.sync3      <= 7'h00;
      q.level      <= 7'h00;
      q.prdata     <= 32'h0000_0000;
      q.slverr     <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------------
  // Serial outputs are cut while disabled; general I/O keeps its own
  // direction since software owns those pins outright.
  assign active = (q.unit != spio_pkg::UNIT_OFF);

  always_comb begin
    for (int i = 0; i < spio_pkg::PIN_COUNT; i++) begin
      if (q.cfg.pio_sel[i]) begin
        drv.oe[i]  = q.cfg.oe[i];
        drv.out[i] = q.cfg.odata[i];
      end else begin
        drv.oe[i]  = ser_oe[i] & active;
        drv.out[i] = ser_out[i];
      end
      // Open drain only ever pulls low; a one releases the pin
      // Open drain and direction act alike in both pin functions
      if (q.cfg.odrain[i]) begin
        pin_oe[i]  = drv.oe[i] & ~drv.out[i];
        pin_out[i] = 1'b0;
      end else begin
        pin_oe[i]  = drv.oe[i];
        pin_out[i] = drv.out[i];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign prdata                      = q.prdata;
  // The error flag only qualifies an access phase
  assign pslverr                     = pready & q.slverr;
  assign ser_pin_level               = q.level;
  assign unit_enabled                = active;
  assign transmit_holding_empty_flag = q.tx_empty;
  assign soft_reset_pulse            = soft_rst;
  assign pio_clk_on                  = q.clk_gate[spio_pkg::CLK_PIO_BIT];
  assign ser_clk_on                  = q.clk_gate[spio_pkg::CLK_SER_BIT];

endmodule : spio_pin_ctrl

// [tb/spio_pin_ctrl_assertions.sv]
`timescale 1ns/10ps
module spio_pin_ctrl_assertions #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              clk_en,
  // Register bus
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Unit state
  input wire logic              xfer_busy,
  input wire logic              master_conflict_fault,
  input wire logic              unit_enabled,
  input wire logic              transmit_holding_empty_flag,
  input wire logic              soft_reset_pulse,
  input wire logic              pio_clk_on,
  input wire logic              ser_clk_on
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic en_wr;
  assign en_wr = psel && penable && pwrite && clk_en && pwdata[spio_pkg::CTRL_EN_BIT]
                 && paddr == ADDR_W'(spio_pkg::OFS_UNIT_CTRL);

  sequence s_wr(logic [7:0] a, int b);
    psel && penable && pwrite && clk_en && paddr == a && pwdata[b];
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_clk_set_on: assert property (s_wr(spio_pkg::OFS_CLK_SET, 0) |=> pio_clk_on)
    else $error("clock set write did not start pin clock");
  a_clk_clear_off: assert property (s_wr(spio_pkg::OFS_CLK_CLEAR, 1) |=> !ser_clk_on)
    else $error("clock clear write did not stop serial clock");
  a_clk_status_kept: assert property (soft_reset_pulse |=> $stable({pio_clk_on, ser_clk_on}))
    else $error("clock status changed by soft reset");
  a_soft_rst_cause: assert property (soft_reset_pulse |-> s_wr(spio_pkg::OFS_UNIT_CTRL, 0))
    else $error("soft reset pulse without control write");
  a_enable_on: assert property (s_wr(spio_pkg::OFS_UNIT_CTRL, 1) ##0
    (!pwdata[2] && !master_conflict_fault) |=> unit_enabled && transmit_holding_empty_flag)
    else $error("enable write did not enable unit");
  a_disable_off: assert property (s_wr(spio_pkg::OFS_UNIT_CTRL, 2) ##0 !xfer_busy
    |=> !unit_enabled)
    else $error("idle disable write left unit enabled");
  a_drain_holds: assert property (s_wr(spio_pkg::OFS_UNIT_CTRL, 2) ##0 (xfer_busy
    && unit_enabled && !pwdata[0] && !master_conflict_fault) |=> unit_enabled)
    else $error("disable cut a running transfer");
  a_fault_off: assert property (master_conflict_fault && !en_wr |=> !unit_enabled)
    else $error("unit still enabled after mode fault");
  a_stay_off: assert property (!unit_enabled && !en_wr |=> !unit_enabled)
    else $error("unit enabled without enable write");
  // Offset 0x0c is a hole in the map and must be refused
  a_err_ready: assert property ((pslverr |-> pready) and
    (pready && paddr == ADDR_W'(8'h0c) |-> pslverr))
    else $error("error flag wrong for access phase");
endmodule : spio_pin_ctrl_assertions

// [tb/spio_far_pins.sv]
`timescale 1ns/10ps
module spio_far_pins (
  // Design side
  input  wire logic [6:0] pin_out,
  input  wire logic [6:0] pin_oe,
  // Far devices
  input  wire logic [6:0] ext_en,
  input  wire logic [6:0] ext_val,
  // Resolved lines
  output logic      [6:0] pin_in
);
  // ----------------------------------------------------------------
  // Line resolution
  // ----------------------------------------------------------------
  // Pull-ups hold a released line high, so a stale level never shows
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_val[i];
      end else begin
        pin_in[i] = 1'b1;
      end
    end
  end
endmodule : spio_far_pins

// [tb/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, last_err;
  logic [6:0]  pin_in, pin_out, pin_oe, ser_pin_level;
  logic [6:0]  ser_out = 7'h55;
  logic [6:0]  ext_en = 7'h00;
  logic [6:0]  ext_val = 7'h00;
  logic        xfer_busy = 1'b0;
  logic        fault = 1'b0;
  logic        tx_load = 1'b0, tx_take = 1'b0;
  logic        unit_enabled, tx_empty, soft_pulse, pio_clk_on, ser_clk_on;
  int          mismatches = 0;
  int          n_tests = 0;

  always #20 pclk = ~pclk;

  spio_pin_ctrl #(.ADDR_W(8)) u_dut (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .ser_out(ser_out), .ser_oe(7'h7f), .xfer_busy(xfer_busy),
    .master_conflict_fault(fault), .tx_load(tx_load), .tx_take(tx_take),
    .ser_pin_level(ser_pin_level), .unit_enabled(unit_enabled),
    .transmit_holding_empty_flag(tx_empty), .soft_reset_pulse(soft_pulse),
    .pio_clk_on(pio_clk_on), .ser_clk_on(ser_clk_on));

  spio_far_pins u_far (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
    .ext_val(ext_val), .pin_in(pin_in));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      mismatches++;
      end_of_test();
    end
    q = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    check(name, q, exp);
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] q;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd("func", 8'h08, 32'h007f0000);
    rd("oe", 8'h18, 32'h0);
    rd("lvl", 8'h38, 32'h0);
    rd("od", 8'h48, 32'h0);
    rd("clk", 8'h58, 32'h0);
    wr(8'h08, 32'h0);
    rd("func_ro", 8'h08, 32'h007f0000);
    apb(1'b0, 8'h0c, 32'h0, q);
    check("unmapped_err", {31'h0, last_err}, 32'h1);
    check("unmapped_data", q, 32'h0);
    wr(8'h04, 32'h00050000);
    rd("func_dis", 8'h08, 32'h007a0000);
    wr(8'h00, 32'h00010000);
    wr(8'h04, 32'h0);
    rd("func_en", 8'h08, 32'h007b0000);
    wr(8'h10, 32'h00030000);
    rd("oe_set", 8'h18, 32'h00030000);
    wr(8'h14, 32'h00010000);
    rd("oe_clr", 8'h18, 32'h00020000);
    wr(8'h30, 32'h00060000);
    rd("lvl_set", 8'h38, 32'h00060000);
    wr(8'h34, 32'h00020000);
    rd("lvl_clr", 8'h38, 32'h00040000);
    wr(8'h50, 32'h3);
    rd("clk_on", 8'h58, 32'h3);
    check("clk_outs", {30'h0, ser_clk_on, pio_clk_on}, 32'h3);
    wr(8'h54, 32'h2);
    rd("clk_off", 8'h58, 32'h1);
    wr(8'h50, 32'h2);
    wr(8'h00, 32'h007f0000);
    wr(8'h14, 32'h007f0000);
    ext_en  <= 7'h7f;
    ext_val <= 7'h2a;
    tick(6);
    rd("pins_in", 8'h3c, 32'h002a0000);
    check("pins_lvl", {25'h0, ser_pin_level}, 32'h2a);
    wr(8'h10, 32'h00040000);
    ext_en <= 7'h7b;
    tick(6);
    rd("pins_drv", 8'h3c, 32'h002e0000);
    wr(8'h40, 32'h00040000);
    rd("od_set", 8'h48, 32'h00040000);
    check("od_high", {25'h0, pin_oe}, 32'h0);
    wr(8'h34, 32'h00040000);
    check("od_low", {25'h0, pin_oe}, 32'h4);
    tick(6);
    rd("od_pins", 8'h3c, 32'h002a0000);
    wr(8'h44, 32'h00040000);
    rd("od_clr", 8'h48, 32'h0);
    wr(8'h60, 32'h1);
    rd("rst_func", 8'h08, 32'h007f0000);
    rd("rst_oe", 8'h18, 32'h0);
    rd("rst_lvl", 8'h38, 32'h0);
    rd("rst_clk", 8'h58, 32'h3);
    wr(8'h04, 32'h00010000);
    wr(8'h60, 32'h0);
    rd("ctrl_zero", 8'h08, 32'h007e0000);
    // Serial function on every pin until the closing soft reset
    wr(8'h04, 32'h007f0000);
    ext_en <= 7'h00;
    check("off_oe", {25'h0, pin_oe}, 32'h0);
    wr(8'h60, 32'h2);
    check("on", {31'h0, unit_enabled}, 32'h1);
    check("txe_on", {31'h0, tx_empty}, 32'h1);
    check("on_oe", {25'h0, pin_oe}, 32'h7f);
    check("on_out", {25'h0, pin_out}, 32'h55);
    rd("stat_on", 8'h70, 32'h102);
    wr(8'h60, 32'h6);
    check("both", {31'h0, unit_enabled}, 32'h0);
    check("dis_oe", {25'h0, pin_oe}, 32'h0);
    check("txe_off", {31'h0, tx_empty}, 32'h0);
    wr(8'h60, 32'h2);
    xfer_busy <= 1'b1;
    wr(8'h60, 32'h4);
    check("drain", {31'h0, unit_enabled}, 32'h1);
    rd("stat_drn", 8'h70, 32'h302);
    xfer_busy <= 1'b0;
    tick(3);
    check("drained", {31'h0, unit_enabled}, 32'h0);
    wr(8'h60, 32'h2);
    fault <= 1'b1;
    tick(1);
    fault <= 1'b0;
    tick(4);
    check("fault", {31'h0, unit_enabled}, 32'h0);
    rd("stat_flt", 8'h70, 32'h4);
    wr(8'h60, 32'h2);
    check("re_en", {31'h0, unit_enabled}, 32'h1);
    tx_load <= 1'b1;
    tick(1);
    tx_load <= 1'b0;
    tick(1);
    check("txe_load", {31'h0, tx_empty}, 32'h0);
    {tx_load, tx_take} <= 2'b11;
    tick(1);
    {tx_load, tx_take} <= 2'b00;
    tick(1);
    check("txe_take", {31'h0, tx_empty}, 32'h1);
    wr(8'h60, 32'h1);
    check("srst_off", {31'h0, unit_enabled}, 32'h0);
    check("srst_txe", {31'h0, tx_empty}, 32'h0);
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    tick(1);
    rd("hw_clk", 8'h58, 32'h0);
    end_of_test();
  end
endmodule : tb_top

bind spio_pin_ctrl spio_pin_ctrl_assertions #(.ADDR_W(ADDR_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .xfer_busy(xfer_busy), .master_conflict_fault(master_conflict_fault),
  .unit_enabled(unit_enabled), .transmit_holding_empty_flag(transmit_holding_empty_flag),
  .soft_reset_pulse(soft_reset_pulse), .pio_clk_on(pio_clk_on), .ser_clk_on(ser_clk_on));
